// ==== rtl/fcoc_pkg.sv ====
// package: register map, field layout and constants of the flash clock and option control
package fcoc_pkg;

    // ==========================================================
    // bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CLK_DIV  = 12'h000; // flash_clock_divider
    localparam logic [ADDR_W-1:0] ADDR_OPTION   = 12'h004; // flash_option_settings
    localparam logic [ADDR_W-1:0] ADDR_KEY_CFG  = 12'h008; // key access control
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 12'h00C; // security status
    localparam logic [ADDR_W-1:0] ADDR_KEY_BASE = 12'h010; // first of eight key byte slots
    localparam logic [ADDR_W-1:0] ADDR_KEY_LAST = 12'h02C; // last key byte slot

    // ==========================================================
    // divider register fields
    localparam int unsigned DIV_LOADED_BIT = 7;
    localparam int unsigned DIV_PRESC_BIT  = 6;
    localparam int unsigned DIV_FIELD_W    = 6;
    localparam logic [2:0]  PRESCALE_LAST  = 3'h7;  // bus clock divided by 8
    localparam logic [6:0]  DIV_CTRL_RESET = 7'h00;

    // ==========================================================
    // option register fields
    localparam int unsigned OPT_BACKDOOR_UNLOCK_ENABLE_BIT = 7;
    localparam int unsigned OPT_NORED_BIT = 6;
    localparam logic [1:0]  SEC_UNSECURED = 2'h2;
    localparam logic [1:0]  SEC_RESET     = 2'h3;  // erased state: secured
    localparam logic [7:0]  OPT_RESET     = 8'h03;

    // ==========================================================
    // key access control and status fields
    localparam int unsigned CFG_KEYACC_BIT  = 0;
    localparam int unsigned STAT_SECURE_BIT = 0;
    localparam int unsigned STAT_LOADED_BIT = 1;
    localparam int unsigned STAT_UNLOCK_BIT = 2;

    // ==========================================================
    // backdoor key geometry
    localparam int unsigned KEY_BYTES = 8;
    localparam int unsigned KEY_IDX_W = 3;
    localparam logic [3:0]  KEY_COUNT_FULL = 4'h8;

endpackage : fcoc_pkg

// ==== rtl/fcoc_key_if.sv ====
// interface: key byte traffic between the register block and the key comparator
interface fcoc_key_if;
    logic       arm;     // key access mode, level
    logic       wr;      // key byte write, one-cycle pulse
    logic [2:0] idx;     // slot written
    logic [7:0] data;    // byte written
    logic       finish;  // key access mode left, one-cycle pulse
    logic       unlock;  // key matched, one-cycle pulse

    modport ctl (output arm, output wr, output idx, output data, output finish, input unlock);
    modport cmp (input arm, input wr, input idx, input data, input finish, output unlock);
endinterface : fcoc_key_if

// ==== rtl/fcoc_clkdiv.sv ====
// module: divider producing the flash timing enable pulse from the bus clock
module fcoc_clkdiv
    import fcoc_pkg::*;
(
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // settings
    input  wire logic                   enable,
    input  wire logic                   prescale,
    input  wire logic [DIV_FIELD_W-1:0] divisor,
    // timing pulse
    output logic                        tick
);

    logic [2:0]             pre_reg;
    logic [DIV_FIELD_W-1:0] cnt_reg;

    // ==========================================================
    // input selection: every cycle, or every eighth with prescale
    wire pre_end  = (pre_reg == PRESCALE_LAST);
    wire step     = enable & (~prescale | pre_end);
    wire cnt_zero = (cnt_reg == '0);

    // prescale counter free runs so the 1-of-8 enable is even
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 3'h0;
        end else begin
            pre_reg <= enable ? pre_reg + 3'h1 : 3'h0;
        end
    end

    // down counter reloads with divisor: period is divisor plus one steps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else begin
            tick <= step & cnt_zero;
            if (step) begin
                cnt_reg <= cnt_zero ? divisor : cnt_reg - 1'b1;
            end
        end
    end

endmodule // fcoc_clkdiv

// ==== rtl/fcoc_keycmp.sv ====
// module: in-order backdoor key comparison against the stored key
module fcoc_keycmp
    import fcoc_pkg::*;
(
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // stored key and enable
    input  wire logic [8*KEY_BYTES-1:0] stored_unlock_key,
    input  wire logic                 backdoor_unlock_enable,
    // key traffic
    fcoc_key_if.cmp                   key
);

    logic [3:0] count_reg;
    logic       bad_reg;

    // byte compared on the fly, so the key entered is never stored
    wire [7:0] expect_byte = stored_unlock_key[8*key.idx +: 8];
    wire       in_order    = ({1'b0, key.idx} == count_reg);
    wire       byte_ok     = in_order & (key.data == expect_byte);
    wire       match       = (count_reg == KEY_COUNT_FULL) & ~bad_reg;

    // ==========================================================
    // sequence tracking; restarts whenever key access mode ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg  <= 4'h0;
            bad_reg    <= 1'b0;
            key.unlock <= 1'b0;
        end else begin
            key.unlock <= key.finish & match & backdoor_unlock_enable;
            if (key.finish) begin
                count_reg <= 4'h0;
                bad_reg   <= 1'b0;
            end else if (key.arm && key.wr) begin
                count_reg <= (count_reg == KEY_COUNT_FULL) ? count_reg : count_reg + 4'h1;
                bad_reg   <= bad_reg | ~byte_ok | (count_reg == KEY_COUNT_FULL);
            end
        end
    end

endmodule // fcoc_keycmp

// ==== rtl/fcoc_top.sv ====
// module: flash clock divider, option register and security state behind an APB slave
//
// Operation
// - divisor-loaded flag set by first divider write
// - divisor bits accept one write after reset
// - erase and program refused until divisor loaded
// - prescale bit selects bus clock or divided-by-8
// - divider divides by divisor field plus one
// - timing pulse is one bus clock cycle
// - option byte copied into option register at the first edge after reset
// - option bits 5:2 zero, register read-only
// - key disabled means no backdoor unlock
// - key writes from firmware only, not debug
// - matching eight in-order key bytes unlock until reset
// - option bit 6 disables vector redirection
// - security code 10 unsecured, others secured
// - secured blocks unsecured access to memories
// - key match or blank check pass unsecures
// - blocked writes ignored, blocked reads return zero
//
// The address map and the APB interface to the registers were decided locally.
module fcoc_top
    import fcoc_pkg::*;
(
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [fcoc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [fcoc_pkg::DATA_W-1:0] pwdata,
    output logic [fcoc_pkg::DATA_W-1:0]     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // source of the current bus access
    input  wire logic                       access_from_debug,
    // nonvolatile contents
    input  wire logic [7:0]                 stored_option_byte,
    input  wire logic [63:0]                stored_unlock_key,
    // sequencer hooks
    input  wire logic                       np_cmd_req,
    input  wire logic                       blank_check_pass,
    output logic                            np_cmd_grant,
    output logic                            np_cmd_refused,
    output logic                            flash_clock_tick,
    // memory access gate
    input  wire logic                       mem_req,
    input  wire logic                       mem_write,
    input  wire logic                       mem_src_unsecure,
    input  wire logic [7:0]                 mem_rdata_raw,
    output logic                            mem_write_en,
    output logic [7:0]                      mem_rdata,
    // state outputs
    output logic                            secured,
    output logic                            vector_redirect_disable,
    output logic                            backdoor_unlock_enable
);
    import fcoc_pkg::*;

    fcoc_key_if key_bus ();

    // ==========================================================
    // state
    logic                   divisor_loaded_flag_reg;
    logic                   prescale_by_eight_reg;
    logic [DIV_FIELD_W-1:0] clock_divisor_field_reg;
    logic                   opt_loaded_reg;
    logic                   backdoor_unlock_enable_reg;
    logic                   nored_reg;
    logic [1:0]             security_code_reg;
    logic                   key_access_reg;
    logic                   unlocked_reg;
    logic                   tick_w;

    // ==========================================================
    // apb phases: one wait state, the write lands on the pready edge
    wire acc_phase = psel & penable;
    wire xfer_done = acc_phase & pready;
    wire do_write  = xfer_done & pwrite;

    // address decode
    wire hit_div    = (paddr == ADDR_CLK_DIV);
    wire hit_opt    = (paddr == ADDR_OPTION);
    wire hit_cfg    = (paddr == ADDR_KEY_CFG);
    wire hit_stat   = (paddr == ADDR_STATUS);
    wire hit_key    = (paddr >= ADDR_KEY_BASE) && (paddr <= ADDR_KEY_LAST)
                      && (paddr[1:0] == 2'h0);
    wire hit_any    = hit_div | hit_opt | hit_cfg | hit_stat | hit_key;
    wire [ADDR_W-1:0] key_off = paddr - ADDR_KEY_BASE;

    // security code 10 alone is unsecured; declared ahead of the status image that reads it
    wire secured_w = (security_code_reg != SEC_UNSECURED);

    // register images
    wire [7:0] div_image  = {divisor_loaded_flag_reg, prescale_by_eight_reg,
                             clock_divisor_field_reg};
    wire [7:0] opt_image  = {backdoor_unlock_enable_reg, nored_reg, 4'h0, security_code_reg};
    wire [7:0] cfg_image  = {7'h00, key_access_reg};
    wire [7:0] stat_image = {5'h00, unlocked_reg, opt_loaded_reg, secured_w};
    wire [7:0] rd_byte    = hit_div  ? div_image  :
                            hit_opt  ? opt_image  :
                            hit_cfg  ? cfg_image  :
                            hit_stat ? stat_image : 8'h00;

    // ==========================================================
    // bus answer; key slots read zero, unmapped addresses give an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_phase & ~pready;
            prdata  <= (acc_phase & ~pready & ~pwrite) ? {24'h000000, rd_byte} : '0;
            pslverr <= acc_phase & ~pready & ~hit_any;
        end
    end

    // ==========================================================
    // divider register: one write after reset, flag set whatever the data
    wire div_wr = do_write & hit_div;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divisor_loaded_flag_reg <= 1'b0;
            prescale_by_eight_reg   <= DIV_CTRL_RESET[DIV_PRESC_BIT];
            clock_divisor_field_reg <= DIV_CTRL_RESET[DIV_FIELD_W-1:0];
        end else if (div_wr && !divisor_loaded_flag_reg) begin
            divisor_loaded_flag_reg <= 1'b1;
            prescale_by_eight_reg   <= pwdata[DIV_PRESC_BIT];
            clock_divisor_field_reg <= pwdata[DIV_FIELD_W-1:0];
        end
    end

    // ==========================================================
    // timing pulse; counter idles until a divisor is written
    fcoc_clkdiv u_clkdiv (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (divisor_loaded_flag_reg),
        .prescale (prescale_by_eight_reg),
        .divisor  (clock_divisor_field_reg),
        .tick     (tick_w)
    );

    // one pulse per flash clock period paces the sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_clock_tick <= 1'b0;
        end else begin
            flash_clock_tick <= tick_w;
        end
    end

    // ==========================================================
    // erase and program gating by the divisor-loaded flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            np_cmd_grant   <= 1'b0;
            np_cmd_refused <= 1'b0;
        end else begin
            np_cmd_grant   <= np_cmd_req &  divisor_loaded_flag_reg;
            np_cmd_refused <= np_cmd_req & ~divisor_loaded_flag_reg;
        end
    end

    // ==========================================================
    // option register: reset holds the secure erased image, the stored
    // byte is caught at the first edge after release since an async
    // reset may only load a constant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_loaded_reg <= 1'b0;
            backdoor_unlock_enable_reg      <= OPT_RESET[OPT_BACKDOOR_UNLOCK_ENABLE_BIT];
            nored_reg      <= OPT_RESET[OPT_NORED_BIT];
        end else if (!opt_loaded_reg) begin
            opt_loaded_reg <= 1'b1;
            backdoor_unlock_enable_reg      <= stored_option_byte[OPT_BACKDOOR_UNLOCK_ENABLE_BIT];
            nored_reg      <= stored_option_byte[OPT_NORED_BIT];
        end
    end

    // security code: loaded once, then only forced to unsecured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            security_code_reg <= SEC_RESET;
        end else if (!opt_loaded_reg) begin
            security_code_reg <= stored_option_byte[1:0];
        end else if (key_bus.unlock || blank_check_pass) begin
            security_code_reg <= SEC_UNSECURED;
        end
    end

    // ==========================================================
    // key access: debug-port writes never reach the comparator
    wire fw_write = do_write & ~access_from_debug;
    wire cfg_wr   = fw_write & hit_cfg;
    wire keyacc_n = pwdata[CFG_KEYACC_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_access_reg <= 1'b0;
            unlocked_reg   <= 1'b0;
        end else begin
            if (cfg_wr) begin
                key_access_reg <= keyacc_n;
            end
            if (key_bus.unlock) begin
                unlocked_reg <= 1'b1;
            end
        end
    end

    assign key_bus.arm    = key_access_reg;
    assign key_bus.wr     = fw_write & hit_key & key_access_reg;
    assign key_bus.idx    = key_off[KEY_IDX_W+1:2];
    assign key_bus.data   = pwdata[7:0];
    assign key_bus.finish = cfg_wr & key_access_reg & ~keyacc_n;

    fcoc_keycmp u_keycmp (
        .pclk                   (pclk),
        .presetn                (presetn),
        .stored_unlock_key      (stored_unlock_key),
        .backdoor_unlock_enable (backdoor_unlock_enable_reg),
        .key                    (key_bus)
    );

    // ==========================================================
    // memory gate: blocked writes dropped, blocked reads forced to zero
    wire blocked = mem_req & mem_src_unsecure & secured_w;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_write_en <= 1'b0;
            mem_rdata    <= 8'h00;
        end else begin
            mem_write_en <= mem_req & mem_write & ~blocked;
            mem_rdata    <= (mem_req & ~mem_write & ~blocked) ? mem_rdata_raw : 8'h00;
        end
    end

    // ==========================================================
    // state outputs, registered for a clean boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secured                 <= 1'b1;
            vector_redirect_disable <= 1'b0;
            backdoor_unlock_enable  <= 1'b0;
        end else begin
            secured                 <= secured_w;
            vector_redirect_disable <= nored_reg;
            backdoor_unlock_enable  <= backdoor_unlock_enable_reg;
        end
    end

endmodule // fcoc_top

// ==== dv/fcoc_checker.sv ====
// checker: bus, gate and option relations of the flash clock and option control
module fcoc_checker
    import fcoc_pkg::*;
(
    // clock and reset
    input wire logic                         pclk,
    input wire logic                         presetn,
    // apb slave
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [fcoc_pkg::ADDR_W-1:0]  paddr,
    input wire logic [fcoc_pkg::DATA_W-1:0]  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    // nonvolatile contents and sequencer hooks
    input wire logic [7:0]                   stored_option_byte,
    input wire logic                         np_cmd_req,
    input wire logic                         blank_check_pass,
    input wire logic                         np_cmd_grant,
    input wire logic                         np_cmd_refused,
    // memory gate
    input wire logic                         mem_req,
    input wire logic                         mem_write,
    input wire logic                         mem_src_unsecure,
    input wire logic [7:0]                   mem_rdata_raw,
    input wire logic                         mem_write_en,
    input wire logic [7:0]                   mem_rdata,
    // state outputs
    input wire logic                         secured,
    input wire logic                         vector_redirect_disable,
    input wire logic                         backdoor_unlock_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       loaded_q;
    logic [1:0] seen;
    logic [7:0] opt_q;
    wire        rd_done = psel && penable && pready && !pwrite;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================================
    // reference state rebuilt from the bus, independent of the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_q <= 1'h0;
        end else if (psel && penable && pready && pwrite && paddr == ADDR_CLK_DIV) begin
            loaded_q <= 1'h1;
        end
    end
    // seen counts edges out of reset so early cycles are not judged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen <= 2'h0;
        end else if (seen != 2'h3) begin
            seen <= seen + 2'h1;
        end
    end
    // keeps the byte present at the first edge after release
    always_ff @(posedge pclk) begin
        if (seen == 2'h0) begin
            opt_q <= stored_option_byte;
        end
    end

    // ==========================================================
    // assertions
    a_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait state");
    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("error response outside a transfer answer");
    a_loaded_flag: assert property (
        rd_done && paddr == ADDR_CLK_DIV |-> prdata[7] == loaded_q)
        else $error("divisor loaded flag disagrees with bus history");
    a_option_read: assert property (
        rd_done && paddr == ADDR_OPTION && seen[1] |-> prdata[7:2] == {opt_q[7:6], 4'h0})
        else $error("option read differs from captured option byte");
    a_grant_gate: assert property (
        np_cmd_req |=> np_cmd_grant == $past(loaded_q) && np_cmd_refused != $past(loaded_q))
        else $error("erase or program gate ignores divisor loaded state");
    // the gate uses the internal state, which the secured output shows one edge later
    a_mem_block: assert property (
        mem_req && mem_src_unsecure ##1 secured |-> !mem_write_en && mem_rdata == 8'h00)
        else $error("unsecured access reached secure memory");
    a_mem_pass: assert property (
        mem_req && !mem_src_unsecure |=> mem_write_en == $past(mem_write)
            && mem_rdata == ($past(mem_write) ? 8'h00 : $past(mem_rdata_raw)))
        else $error("permitted memory access altered by the gate");
    a_blank_unsec: assert property (
        blank_check_pass && seen != 2'h0 |-> ##2 !secured)
        else $error("passing blank check did not unsecure");
    a_sec_sticky: assert property (!secured |=> !secured)
        else $error("security came back without a reset");
    a_opt_outputs: assert property (
        seen[1] |-> vector_redirect_disable == opt_q[6] && backdoor_unlock_enable == opt_q[7])
        else $error("option outputs differ from loaded option byte");
endmodule // fcoc_checker

bind fcoc_top fcoc_checker u_fcoc_checker (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .stored_option_byte, .np_cmd_req, .blank_check_pass,
    .np_cmd_grant, .np_cmd_refused, .mem_req, .mem_write, .mem_src_unsecure, .mem_rdata_raw,
    .mem_write_en, .mem_rdata,
    .secured, .vector_redirect_disable, .backdoor_unlock_enable);

// ==== dv/tb_flash_clock_and_option_control.sv ====
// testbench: flash clock divider, option register and security state through apb
module tb_flash_clock_and_option_control
    import fcoc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // design signals and bench state
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, r;
    logic [7:0]        ob, mem_rdata_raw, mem_rdata;
    logic [63:0]       key;
    logic [6:0]        d;
    logic              access_from_debug, np_cmd_req, blank_check_pass, np_cmd_grant;
    logic              np_cmd_refused, flash_clock_tick, mem_req, mem_write, mem_src_unsecure;
    logic              mem_write_en, secured, vector_redirect_disable, backdoor_unlock_enable;
    integer            seed, bad_count, n_checks, g;

    fcoc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .access_from_debug, .stored_option_byte(ob), .stored_unlock_key(key),
        .np_cmd_req, .blank_check_pass, .np_cmd_grant, .np_cmd_refused, .flash_clock_tick,
        .mem_req, .mem_write, .mem_src_unsecure, .mem_rdata_raw, .mem_write_en, .mem_rdata,
        .secured, .vector_redirect_disable, .backdoor_unlock_enable);

    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end

    // random memory traffic keeps the gate busy in both security states
    always @(posedge pclk) begin
        {mem_req, mem_write, mem_src_unsecure, mem_rdata_raw} <= 11'($random(seed));
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] opt_exp();
        return {24'h0, ob[7:6], 4'h0, ob[1:0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one apb transfer; an idle cycle follows so strobes never toggle in one step
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 64);
        if (n >= 64) begin
            bad_count++;
            finish_test();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic do_reset(input logic [7:0] o);
        ob      <= o;
        presetn <= 1'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
    endtask

    task automatic cmd(input logic ok);
        np_cmd_req <= 1'h1;
        @(posedge pclk);
        np_cmd_req <= 1'h0;
        @(posedge pclk);
        check("grant", np_cmd_grant, ok);
        check("refused", np_cmd_refused, !ok);
    endtask

    task automatic key_seq(input logic dbg, input logic [63:0] k, input logic exp_sec);
        access_from_debug <= dbg;
        apb(1'h1, ADDR_KEY_CFG, 32'h1);
        for (int i = 0; i < KEY_BYTES; i++) begin
            apb(1'h1, ADDR_KEY_BASE + ADDR_W'(4 * i), {24'h0, k[8*i +: 8]});
        end
        apb(1'h1, ADDR_KEY_CFG, 32'h0);
        access_from_debug <= 1'h0;
        repeat (4) @(posedge pclk);
        check("secured after key", secured, exp_sec);
        apb(1'h0, ADDR_STATUS, 32'h0);
        check("status", r, {29'h0, ~exp_sec, 1'h1, exp_sec});
    endtask

    // edges between two timing pulses
    task automatic tick_gap(input int exp);
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (flash_clock_tick !== 1'h1 && n < 2000);
        end
        check("tick gap", 32'(n), 32'(exp));
        if (n >= 2000) begin
            finish_test();
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        seed = 99006;
        bad_count = 0;
        n_checks = 0;
        {presetn, psel, penable, pwrite, access_from_debug, np_cmd_req, blank_check_pass} = '0;
        {paddr, pwdata, ob} = '0;
        {mem_req, mem_write, mem_src_unsecure, mem_rdata_raw} = '0;
        key = {$random(seed), $random(seed)};
        // every security code, random upper bits, writes must not stick
        for (int i = 0; i < 4; i++) begin
            g = $random(seed);
            do_reset({g[7:2], 2'(i)});
            apb(1'h0, ADDR_OPTION, 32'h0);
            check("option", r, opt_exp());
            check("secured", secured, 32'(i != 2));
            check("redirect", vector_redirect_disable, ob[6]);
            check("key enable", backdoor_unlock_enable, ob[7]);
            apb(1'h1, ADDR_OPTION, ~r);
            apb(1'h0, ADDR_OPTION, 32'h0);
            check("option kept", r, opt_exp());
        end
        $display("test options done");
        // divider: refused before load, one write only, then pulse period
        apb(1'h1, 12'h100, 32'h0);
        check("unmapped error", e, 1'h1);
        cmd(1'h0);
        d = 7'($random(seed)) & 7'h0F;
        apb(1'h1, ADDR_CLK_DIV, {25'h0, d});
        apb(1'h1, ADDR_CLK_DIV, 32'h7F);
        apb(1'h0, ADDR_CLK_DIV, 32'h0);
        check("divider", r, {24'h0, 1'h1, d});
        cmd(1'h1);
        tick_gap(int'(d) + 1);
        // largest setting with the eight-fold prescale
        do_reset(8'h02);
        apb(1'h1, ADDR_CLK_DIV, 32'h7F);
        tick_gap(512);
        $display("test divider done");
        // key from debug, wrong byte, right key, then key disabled
        do_reset(8'h83);
        key_seq(1'h1, key, 1'h1);
        key_seq(1'h0, key ^ 64'h1, 1'h1);
        key_seq(1'h0, key, 1'h0);
        do_reset(8'h03);
        key_seq(1'h0, key, 1'h1);
        blank_check_pass <= 1'h1;
        @(posedge pclk);
        blank_check_pass <= 1'h0;
        repeat (3) @(posedge pclk);
        check("blank check", secured, 1'h0);
        $display("test security done");
        finish_test();
    end
endmodule // tb_flash_clock_and_option_control
